/* File: core/backlight_cfg_pkg.sv */
// constants for the backlight level, full-scale and ramp configuration registers
package backlight_cfg_pkg;

  // ==========================================================================
  // register offsets (byte index on the serial register port)
  localparam logic [7:0] OFF_BANK_B_LEVEL = 8'h04;
  localparam logic [7:0] OFF_BANK_A_FS = 8'h05;
  localparam logic [7:0] OFF_BANK_B_FS = 8'h06;
  localparam logic [7:0] OFF_POWER_TIMES = 8'h07;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_BANK_B_LEVEL = 8'h00;
  localparam logic [7:0] RST_BANK_A_FS = 8'h1f;
  localparam logic [7:0] RST_BANK_B_FS = 8'h1f;
  localparam logic [7:0] RST_POWER_TIMES = 8'h00;

  // ==========================================================================
  // field positions
  localparam int HYST_BIT = 7;
  localparam int LOWER_BOUND_BIT = 6;
  localparam int FS_MSB = 4;
  localparam int START_MSB = 5;
  localparam int START_LSB = 3;
  localparam int SHUT_MSB = 2;
  localparam int SHUT_LSB = 0;

  // ==========================================================================
  // pwm sampler thresholds
  localparam logic [7:0] SAMP_STEP_HYST = 8'h03;
  localparam logic [7:0] SAMP_STEP_FINE = 8'h01;
  localparam logic [7:0] SAMP_FLOOR_CODE = 8'h06;
  localparam logic [7:0] SAMP_ZERO_MAX = 8'h01;

  // ==========================================================================
  // ramp times in microseconds, and clock rate
  localparam longint CLK_MHZ = 125;
  localparam longint T_START0_US = 4000;
  localparam longint T_SHUT0_US = 500;
  localparam longint T_C1_US = 261000;
  localparam longint T_C2_US = 522000;
  localparam longint T_C3_US = 1045000;
  localparam longint T_C4_US = 2091000;
  localparam longint T_C5_US = 4182000;
  localparam longint T_C6_US = 8364000;
  localparam longint T_C7_US = 16730000;

  // ==========================================================================
  // serial port
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a; // arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage

/* File: core/serial_reg_port.sv */
// two-wire serial slave giving byte access to a register pointer
`timescale 1ns/100ps
`default_nettype none

module serial_reg_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // two-wire pins, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // register side
  input wire logic [6:0] dev_addr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  input wire logic [7:0] reg_rdata
);
  import backlight_cfg_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK_A = 3'b010,
    ST_WRITE = 3'b011,
    ST_ACK_W = 3'b100,
    ST_READ = 3'b101,
    ST_RACK = 3'b110,
    ST_RLOAD = 3'b111
  } port_state_t;

  port_state_t state_r;
  logic scl_d_r, sda_d_r, rnw_r, first_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r, tx_r, ptr_r;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  // ==========================================================================
  // edge and bus-condition detection
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_in;
      sda_d_r <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_d_r;
  assign scl_fall = ~scl_in & scl_d_r;
  assign start_cond = scl_in & scl_d_r & sda_d_r & ~sda_in;
  assign stop_cond = scl_in & scl_d_r & ~sda_d_r & sda_in;
  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign reg_addr = ptr_r;

  // ==========================================================================
  // byte sequencer; sda only changes while scl is low
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rnw_r <= 1'b0;
      first_r <= 1'b0;
      sda_oe <= 1'b0;
      reg_wr <= 1'b0;
      reg_wdata <= 8'h00;
    end else begin
      reg_wr <= 1'b0;
      if (stop_cond) begin
        state_r <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_cond) begin
        state_r <= ST_ADDR;
        cnt_r <= 4'h0;
        first_r <= 1'b1;
        sda_oe <= 1'b0;
      end else begin
        case (state_r)
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_in};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
              cnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                if (shift_r[7:1] == dev_addr) begin
                  sda_oe <= 1'b1;
                  rnw_r <= shift_r[0];
                  state_r <= ST_ACK_A;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else begin
                sda_oe <= 1'b1;
                state_r <= ST_ACK_W;
                if (first_r) begin
                  ptr_r <= shift_r; // first data byte sets the pointer
                  first_r <= 1'b0;
                end else begin
                  reg_wdata <= shift_r;
                  reg_wr <= 1'b1;
                end
              end
            end
          end
          ST_ACK_W: begin
            // step only after the strobed write has used the old pointer;
            // the pointer byte itself must not advance it
            if (reg_wr) begin
              ptr_r <= ptr_r + 8'h01; // auto increment after each data byte
            end
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state_r <= ST_WRITE;
            end
          end
          ST_ACK_A, ST_RLOAD: begin
            if (scl_fall) begin
              if (state_r == ST_ACK_A && !rnw_r) begin
                sda_oe <= 1'b0;
                state_r <= ST_WRITE;
              end else begin
                sda_oe <= ~reg_rdata[7];
                tx_r <= {reg_rdata[6:0], 1'b0};
                ptr_r <= ptr_r + 8'h01;
                cnt_r <= 4'h1;
                state_r <= ST_READ;
              end
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (cnt_r == BITS_PER_BYTE) begin
                sda_oe <= 1'b0;
                state_r <= ST_RACK;
              end else begin
                sda_oe <= ~tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
                cnt_r <= cnt_r + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              state_r <= sda_in ? ST_IDLE : ST_RLOAD; // nack ends the read
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/backlight_level_ramp_config.sv */
// bank b level, full-scale current, pwm sampler and power ramp timing registers
`timescale 1ns/100ps
`default_nettype none

module backlight_level_ramp_config #(
  parameter longint unsigned START0_CYC = backlight_cfg_pkg::T_START0_US * backlight_cfg_pkg::CLK_MHZ,
  parameter longint unsigned SHUT0_CYC = backlight_cfg_pkg::T_SHUT0_US * backlight_cfg_pkg::CLK_MHZ,
  parameter longint unsigned C1_CYC = backlight_cfg_pkg::T_C1_US * backlight_cfg_pkg::CLK_MHZ,
  parameter longint unsigned C2_CYC = backlight_cfg_pkg::T_C2_US * backlight_cfg_pkg::CLK_MHZ,
  parameter longint unsigned C3_CYC = backlight_cfg_pkg::T_C3_US * backlight_cfg_pkg::CLK_MHZ,
  parameter longint unsigned C4_CYC = backlight_cfg_pkg::T_C4_US * backlight_cfg_pkg::CLK_MHZ,
  parameter longint unsigned C5_CYC = backlight_cfg_pkg::T_C5_US * backlight_cfg_pkg::CLK_MHZ,
  parameter longint unsigned C6_CYC = backlight_cfg_pkg::T_C6_US * backlight_cfg_pkg::CLK_MHZ,
  parameter longint unsigned C7_CYC = backlight_cfg_pkg::T_C7_US * backlight_cfg_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // serial register port pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [6:0] dev_addr,
  // sleep status from the sleep control
  input wire logic sleep_status,
  // pwm duty code from the input measurement
  input wire logic [7:0] pwm_code,
  input wire logic pwm_code_valid,
  output logic [7:0] pwm_level,
  // ramp requests and status
  input wire logic start_req,
  input wire logic shut_req,
  output logic ramp_busy,
  output logic ramp_done,
  // codes to the current sinks
  output logic [7:0] bank_b_level,
  output logic [4:0] bank_a_full_scale,
  output logic [4:0] bank_b_full_scale
);
  import backlight_cfg_pkg::*;

  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr;
  logic hyst_r, lower_bound_r;
  logic [2:0] start_code_r, shut_code_r;
  logic [7:0] level_r, samp_r;
  logic [4:0] fs_a_r, fs_b_r;
  logic [31:0] ramp_cnt_r;
  logic [7:0] samp_bounded, samp_step;

  // true when a write lands on the given offset
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off, input logic wr);
    hit = wr && (addr == off);
  endfunction

  // ramp length in cycles for a code; code zero differs between start and shut
  function automatic logic [31:0] ramp_cycles(input logic [2:0] code, input logic is_start);
    case (code)
      3'h0: ramp_cycles = is_start ? 32'(START0_CYC) : 32'(SHUT0_CYC);
      3'h1: ramp_cycles = 32'(C1_CYC);
      3'h2: ramp_cycles = 32'(C2_CYC);
      3'h3: ramp_cycles = 32'(C3_CYC);
      3'h4: ramp_cycles = 32'(C4_CYC);
      3'h5: ramp_cycles = 32'(C5_CYC);
      3'h6: ramp_cycles = 32'(C6_CYC);
      default: ramp_cycles = 32'(C7_CYC);
    endcase
  endfunction

  // ==========================================================================
  // serial access
  serial_reg_port u_port (
    .ref_clk(ref_clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .dev_addr(dev_addr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rdata(reg_rdata)
  );

  // ==========================================================================
  // bank b level; sleep freezes it so a wake-up resumes the old value
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      level_r <= RST_BANK_B_LEVEL;
    end else if (hit(reg_addr, OFF_BANK_B_LEVEL, reg_wr) && !sleep_status) begin
      level_r <= reg_wdata; // no floor enforced, host keeps 04h minimum
    end
  end

  // full-scale and sampler controls; bit 5 is not stored
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fs_a_r <= RST_BANK_A_FS[FS_MSB:0];
      hyst_r <= RST_BANK_A_FS[HYST_BIT];
      lower_bound_r <= RST_BANK_A_FS[LOWER_BOUND_BIT];
    end else if (hit(reg_addr, OFF_BANK_A_FS, reg_wr)) begin
      fs_a_r <= reg_wdata[FS_MSB:0];
      hyst_r <= reg_wdata[HYST_BIT];
      lower_bound_r <= reg_wdata[LOWER_BOUND_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fs_b_r <= RST_BANK_B_FS[FS_MSB:0];
    end else if (hit(reg_addr, OFF_BANK_B_FS, reg_wr)) begin
      fs_b_r <= reg_wdata[FS_MSB:0];
    end
  end

  // ramp selections
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      start_code_r <= RST_POWER_TIMES[START_MSB:START_LSB];
      shut_code_r <= RST_POWER_TIMES[SHUT_MSB:SHUT_LSB];
    end else if (hit(reg_addr, OFF_POWER_TIMES, reg_wr)) begin
      start_code_r <= reg_wdata[START_MSB:START_LSB];
      shut_code_r <= reg_wdata[SHUT_MSB:SHUT_LSB];
    end
  end

  // ==========================================================================
  // read back; reserved bits and other offsets read zero
  always_comb begin
    case (reg_addr)
      OFF_BANK_B_LEVEL: reg_rdata = level_r;
      OFF_BANK_A_FS: reg_rdata = {hyst_r, lower_bound_r, 1'b0, fs_a_r};
      OFF_BANK_B_FS: reg_rdata = {3'h0, fs_b_r};
      OFF_POWER_TIMES: reg_rdata = {2'h0, start_code_r, shut_code_r};
      default: reg_rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // pwm sampler: lower bound folds small codes, hysteresis widens the step
  always_comb begin
    if (lower_bound_r || pwm_code > SAMP_FLOOR_CODE) begin
      samp_bounded = pwm_code;
    end else if (pwm_code <= SAMP_ZERO_MAX) begin
      samp_bounded = 8'h00;
    end else begin
      samp_bounded = SAMP_FLOOR_CODE;
    end
    samp_step = hyst_r ? SAMP_STEP_FINE : SAMP_STEP_HYST;
  end

  // small jitter on the duty measure would otherwise flicker the output
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      samp_r <= 8'h00;
    end else if (pwm_code_valid) begin
      if ((samp_bounded >= samp_r + samp_step && samp_r <= 8'hff - samp_step) ||
          (samp_r >= samp_bounded + samp_step && samp_bounded <= 8'hff - samp_step) ||
          (samp_bounded == 8'h00 && samp_r != 8'h00)) begin
        samp_r <= samp_bounded;
      end
    end
  end

  // ==========================================================================
  // ramp timer; a new request restarts it with the latest selection
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ramp_cnt_r <= 32'h0;
      ramp_busy <= 1'b0;
      ramp_done <= 1'b0;
    end else begin
      ramp_done <= 1'b0;
      if (start_req) begin
        ramp_cnt_r <= ramp_cycles(start_code_r, 1'b1) - 32'h1;
        ramp_busy <= 1'b1;
      end else if (shut_req) begin
        ramp_cnt_r <= ramp_cycles(shut_code_r, 1'b0) - 32'h1;
        ramp_busy <= 1'b1;
      end else if (ramp_busy) begin
        if (ramp_cnt_r == 32'h0) begin
          ramp_busy <= 1'b0;
          ramp_done <= 1'b1;
        end else begin
          ramp_cnt_r <= ramp_cnt_r - 32'h1;
        end
      end
    end
  end

  assign bank_b_level = level_r;
  assign bank_a_full_scale = fs_a_r;
  assign bank_b_full_scale = fs_b_r;
  assign pwm_level = samp_r;

endmodule
`default_nettype wire

/* File: test/backlight_cfg_monitor.sv */
// checker of the backlight configuration block ports
`timescale 1ns/100ps
`default_nettype none

module backlight_cfg_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // sampler and sleep
  input wire logic sleep_status,
  input wire logic [7:0] pwm_code,
  input wire logic pwm_code_valid,
  input wire logic [7:0] pwm_level,
  // ramp
  input wire logic start_req,
  input wire logic shut_req,
  input wire logic ramp_busy,
  input wire logic ramp_done,
  // register contents
  input wire logic [7:0] bank_b_level,
  input wire logic [4:0] bank_a_full_scale,
  input wire logic [4:0] bank_b_full_scale
);
  // shortest ramp, and a limit above the longest ramp of 90 cycles, in the shortened bench build
  localparam int RAMP_MIN = 10;
  localparam int RAMP_MAX = 100;
  // ==========================================================================
  // port relations
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_sleep_level_hold: assert property (sleep_status |=> $stable(bank_b_level))
    else $error("level changed in sleep");
  a_reset_full_scale: assert property ($fell(reset) |->
    bank_a_full_scale == 5'h1f && bank_b_full_scale == 5'h1f)
    else $error("full scale reset value");
  a_req_starts_busy: assert property ((start_req || shut_req) |=> ramp_busy)
    else $error("ramp not busy after request");
  a_busy_has_cause: assert property ($rose(ramp_busy) |-> $past(start_req || shut_req))
    else $error("ramp busy without request");
  a_done_one_cycle: assert property (ramp_done |=> !ramp_done)
    else $error("ramp done too long");
  a_ramp_time_bounded: assert property ($rose(ramp_busy) |->
    ##[RAMP_MIN:RAMP_MAX] ramp_done)
    else $error("ramp length out of range");
  a_level_on_valid: assert property ($changed(pwm_level) |-> $past(pwm_code_valid))
    else $error("sampler moved without code");
  a_zero_code_passes: assert property ((pwm_code_valid && pwm_code == 8'h00) |=>
    pwm_level == 8'h00)
    else $error("sampler did not reach zero");
endmodule

bind backlight_level_ramp_config backlight_cfg_monitor i_mon (
  .ref_clk(ref_clk), .reset(reset), .sleep_status(sleep_status),
  .pwm_code(pwm_code), .pwm_code_valid(pwm_code_valid), .pwm_level(pwm_level),
  .start_req(start_req), .shut_req(shut_req), .ramp_busy(ramp_busy),
  .ramp_done(ramp_done), .bank_b_level(bank_b_level),
  .bank_a_full_scale(bank_a_full_scale), .bank_b_full_scale(bank_b_full_scale)
);
`default_nettype wire

/* File: test/i2c_host_model.sv */
// two-wire host model for the register port
`timescale 1ns/100ps
`default_nettype none

module i2c_host_model (
  // clock
  input wire logic ref_clk,
  // two-wire pins, sda open drain
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // quarter bit; the port needs at least two clocks per phase
  localparam int Q = 4;
  // ==========================================================================
  // bus primitives, lines released at time zero
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (Q) @(negedge ref_clk);
  endtask
  // start or repeated start, sda falls while scl high
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  // nine clocks, msb first; data only changes while scl is low
  task automatic xbyte(input logic [7:0] d, input logic m_ack, output logic [7:0] r,
                       output logic nak);
    logic [8:0] s;
    s = {d, !m_ack};
    for (int i = 8; i >= 0; i--) begin
      sda_low = !s[i];
      q();
      scl = 1'b1;
      q();
      s[i] = sda;
      q();
      scl = 1'b0;
      q();
    end
    sda_low = 1'b0;
    r = s[8:1];
    nak = s[0];
  endtask
  // ==========================================================================
  // register access; level codes below 04h are never sent
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d[$],
                    output logic ok);
    logic [7:0] r;
    logic n;
    start();
    xbyte({a, 1'b0}, 1'b0, r, n);
    ok = !n;
    xbyte(p, 1'b0, r, n);
    ok = ok && !n;
    foreach (d[i]) begin
      xbyte(d[i], 1'b0, r, n);
      ok = ok && !n;
    end
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] v,
                    output logic ok);
    logic [7:0] r;
    logic n;
    start();
    xbyte({a, 1'b0}, 1'b0, r, n);
    ok = !n;
    xbyte(p, 1'b0, r, n);
    ok = ok && !n;
    start();
    xbyte({a, 1'b1}, 1'b0, r, n);
    ok = ok && !n;
    xbyte(8'hff, 1'b0, v, n);
    stop();
  endtask
endmodule
`default_nettype wire

/* File: test/test_backlight_level_ramp_config.sv */
// self-checking bench of the backlight configuration registers
`timescale 1ns/100ps
`default_nettype none

module test_backlight_level_ramp_config;
  import backlight_cfg_pkg::*;
  // ramp unit in cycles; short counts keep the run small
  localparam int SIM_UNIT = 10;
  logic ref_clk = 1'b0;
  logic [6:0] dev_addr = DEV_ADDR_DEFAULT;
  logic reset = 1'b1;
  logic sleep_status = 1'b0;
  logic [7:0] pwm_code = 8'h00;
  logic pwm_code_valid = 1'b0;
  logic start_req = 1'b0;
  logic shut_req = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic [7:0] pwm_level;
  logic ramp_busy;
  logic ramp_done;
  logic [7:0] bank_b_level;
  logic [4:0] bank_a_full_scale;
  logic [4:0] bank_b_full_scale;
  wire logic sda;
  int n_mismatch = 0;
  int cmp_count = 0;
  // open-drain data line with pull-up
  assign sda = !(sda_low || (sda_oe && !sda_out));
  // ==========================================================================
  // clock, host and device
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  i2c_host_model i_host (.ref_clk(ref_clk), .scl(scl), .sda_low(sda_low), .sda(sda));
  // short ramp counts keep the run small
  backlight_level_ramp_config #(.START0_CYC(2 * SIM_UNIT), .SHUT0_CYC(SIM_UNIT),
    .C1_CYC(3 * SIM_UNIT), .C2_CYC(4 * SIM_UNIT), .C3_CYC(5 * SIM_UNIT),
    .C4_CYC(6 * SIM_UNIT), .C5_CYC(7 * SIM_UNIT), .C6_CYC(8 * SIM_UNIT),
    .C7_CYC(9 * SIM_UNIT)) i_dut (
    .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .dev_addr(dev_addr), .sleep_status(sleep_status),
    .pwm_code(pwm_code), .pwm_code_valid(pwm_code_valid), .pwm_level(pwm_level),
    .start_req(start_req), .shut_req(shut_req), .ramp_busy(ramp_busy),
    .ramp_done(ramp_done), .bank_b_level(bank_b_level),
    .bank_a_full_scale(bank_a_full_scale), .bank_b_full_scale(bank_b_full_scale));
  // ==========================================================================
  // shared tasks
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wrb(input logic [7:0] p, input logic [7:0] d[$]);
    logic ok;
    i_host.wr(DEV_ADDR_DEFAULT, p, d, ok);
    chk("write ack", 8'h01, {7'h00, ok});
  endtask
  task automatic rdc(input string w, input logic [7:0] p, input logic [7:0] e);
    logic [7:0] v;
    logic ok;
    i_host.rd(DEV_ADDR_DEFAULT, p, v, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk(w, e, v);
  endtask
  // one code strobe; the sampler answers on the next cycle
  task automatic pv(input logic [7:0] c, input logic [7:0] e);
    @(negedge ref_clk);
    pwm_code = c;
    pwm_code_valid = 1'b1;
    @(negedge ref_clk);
    pwm_code_valid = 1'b0;
    chk("pwm level", e, pwm_level);
  endtask
  // counts cycles from busy rise to the done pulse, bounded
  task automatic ramp(input logic st, input int n);
    int c;
    @(negedge ref_clk);
    start_req = st;
    shut_req = !st;
    @(negedge ref_clk);
    start_req = 1'b0;
    shut_req = 1'b0;
    chk("ramp busy", 8'h01, {7'h00, ramp_busy});
    c = 0;
    while (ramp_done !== 1'b1 && c < 300) begin
      @(negedge ref_clk);
      c++;
    end
    if (c >= 300) begin
      n_mismatch++;
      results();
    end
    chk("ramp cycles", n[7:0], c[7:0]);
    repeat (3) @(negedge ref_clk);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset_values();
    rdc("level", OFF_BANK_B_LEVEL, RST_BANK_B_LEVEL);
    rdc("fs a", OFF_BANK_A_FS, RST_BANK_A_FS);
    rdc("fs b", OFF_BANK_B_FS, RST_BANK_B_FS);
    rdc("times", OFF_POWER_TIMES, RST_POWER_TIMES);
    rdc("unmapped", 8'h08, 8'h00);
  endtask
  // burst over all four places; reserved bits must drop
  task automatic t_burst();
    wrb(OFF_BANK_B_LEVEL, '{8'h80, 8'hff, 8'hff, 8'hff});
    rdc("level", OFF_BANK_B_LEVEL, 8'h80);
    rdc("fs a", OFF_BANK_A_FS, 8'hdf);
    rdc("fs b", OFF_BANK_B_FS, 8'h1f);
    rdc("times", OFF_POWER_TIMES, 8'h3f);
    wrb(OFF_BANK_A_FS, '{8'h0a, 8'h15});
    chk("fs a pin", 8'h0a, {3'h0, bank_a_full_scale});
    chk("fs b pin", 8'h15, {3'h0, bank_b_full_scale});
  endtask
  task automatic t_sleep();
    sleep_status = 1'b1;
    wrb(OFF_BANK_B_LEVEL, '{8'h40});
    rdc("sleep level", OFF_BANK_B_LEVEL, 8'h80);
    chk("sleep pin", 8'h80, bank_b_level);
    sleep_status = 1'b0;
    wrb(OFF_BANK_B_LEVEL, '{8'h40});
    chk("wake pin", 8'h40, bank_b_level);
  endtask
  // device moved to another address: old address gets no ack, level kept
  task automatic t_wrong_addr();
    logic ok;
    dev_addr = DEV_ADDR_DEFAULT ^ 7'h01;
    i_host.wr(DEV_ADDR_DEFAULT, OFF_BANK_B_LEVEL, '{8'h55}, ok);
    chk("stray ack", 8'h00, {7'h00, ok});
    dev_addr = DEV_ADDR_DEFAULT;
    chk("stray level", 8'h40, bank_b_level);
  endtask
  // hysteresis on, floor on; then hysteresis off; then floor off
  task automatic t_sampler();
    pv(8'h64, 8'h64);
    pv(8'h66, 8'h64);
    pv(8'h67, 8'h67);
    pv(8'h04, 8'h06);
    pv(8'h01, 8'h00);
    wrb(OFF_BANK_A_FS, '{8'h8a});
    pv(8'h07, 8'h07);
    pv(8'h08, 8'h08);
    wrb(OFF_BANK_A_FS, '{8'hca});
    pv(8'h03, 8'h03);
    pv(8'h00, 8'h00);
  endtask
  task automatic t_ramps();
    for (int k = 0; k < 8; k++) begin
      wrb(OFF_POWER_TIMES, '{{2'b00, k[2:0], k[2:0]}});
      ramp(1'b1, (k == 0) ? 2 * SIM_UNIT : (k + 2) * SIM_UNIT);
      ramp(1'b0, (k == 0) ? SIM_UNIT : (k + 2) * SIM_UNIT);
    end
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    t_reset_values();
    t_burst();
    t_sleep();
    t_wrong_addr();
    t_sampler();
    t_ramps();
    results();
  end
endmodule
`default_nettype wire
